// File: lpe_regs.vh
`ifndef LPE_REGS_VH
`define LPE_REGS_VH

// register byte offsets
`define LPE_OFF_CMD      8'h00
`define LPE_OFF_ARG0     8'h04
`define LPE_OFF_ARG1     8'h08
`define LPE_OFF_DATA0    8'h0C
`define LPE_OFF_DATA1    8'h10
`define LPE_OFF_DATA2    8'h14
`define LPE_OFF_STATUS   8'h18
`define LPE_OFF_LENBYTES 8'h1C
`define LPE_OFF_LENBITS  8'h20
`define LPE_OFF_MODE     8'h24
`define LPE_OFF_SYNC     8'h28

// command opcodes, CMD[3:0]
`define LPE_OP_INSERT    4'h1
`define LPE_OP_SIZE      4'h2
`define LPE_OP_MODE      4'h3
`define LPE_OP_SYNC      4'h4
`define LPE_OP_OPEN      4'h5
`define LPE_OP_CLOSE     4'h6

// status bit positions
`define LPE_ST_BUSY      0
`define LPE_ST_ERR       1
`define LPE_ST_OWN_LO    2
`define LPE_ST_OWN_HI    3
`define LPE_ST_SYNCLOST  4

// session owner codes
`define LPE_OWN_NONE     2'h0
`define LPE_OWN_LOCAL    2'h1
`define LPE_OWN_REMOTE   2'h2

// partition mode index 0..4 is 64..1024 kbit
`define LPE_MODE_64      32'h00000040
`define LPE_MODE_128     32'h00000080
`define LPE_MODE_256     32'h00000100
`define LPE_MODE_512     32'h00000200
`define LPE_MODE_1024    32'h00000400
`define LPE_MODE_RST     3'h4
`define LPE_MODE_ONLYCUR 3'h3

// pattern limits
`define LPE_CAP_BYTES0   18'h02000
`define LPE_REGION_SH0   5'h10
`define LPE_INS_MIN      7'h08
`define LPE_INS_MAX      7'h50
`define LPE_INS_TOP      7'h4F
`define LPE_NBITS_MAX    32'h00000007
`define LPE_NZERO_LIMIT  18'h007FF
`define LPE_NEVEN_LIMIT  18'h04000
`define LPE_SRC_CURRENT  32'hFFFFFFFF
`define LPE_DST_DISCARD  32'hFFFFFFFE
`define LPE_SLOTS        11

// sync threshold
`define LPE_SYNC_MIN     4'h1
`define LPE_SYNC_MAX     4'h9
`define LPE_SYNC_RST     4'h1
`define LPE_ERR_LIMIT    9'h100
`define LPE_WIN_L1       24'h002000
`define LPE_WIN_L2       24'h008000
`define LPE_WIN_L3       24'h020000
`define LPE_WIN_L4       24'h040000
`define LPE_WIN_L5       24'h080000
`define LPE_WIN_L6       24'h100000
`define LPE_WIN_L7       24'h200000
`define LPE_WIN_L8       24'h400000
`define LPE_WIN_L9       24'h800000

`endif

// File: lpe_sync_monitor.v
`timescale 1ns/1ps
`include "lpe_regs.vh"

module lpe_sync_monitor (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire [3:0]  level,
    input  wire        longWord,
    input  wire        bitValid,
    input  wire        bitError,
    output reg         syncLost_q
);

    reg [23:0] bitCnt_q;
    reg [8:0]  errCnt_q;
    reg [3:0]  levelPrev_q;
    wire [23:0] window;
    wire [8:0]  errNext;

    function [23:0] winBits;
        input [3:0] lvl;
        begin
            case (lvl)
                4'h1:    winBits = `LPE_WIN_L1;
                4'h2:    winBits = `LPE_WIN_L2;
                4'h3:    winBits = `LPE_WIN_L3;
                4'h4:    winBits = `LPE_WIN_L4;
                4'h5:    winBits = `LPE_WIN_L5;
                4'h6:    winBits = `LPE_WIN_L6;
                4'h7:    winBits = `LPE_WIN_L7;
                4'h8:    winBits = `LPE_WIN_L8;
                default: winBits = `LPE_WIN_L9;
            endcase
        end
    endfunction

    assign window  = winBits(level); // R11
    assign errNext = errCnt_q + {8'h00, bitError};

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bitCnt_q    <= 24'h000000;
            errCnt_q    <= 9'h000;
            levelPrev_q <= `LPE_SYNC_RST;
            syncLost_q  <= 1'b0;
        end else begin
            levelPrev_q <= level;
            // short-word and pseudo_random_pattern traffic never loses sync here
            if (!longWord || level != levelPrev_q) begin // R10
                bitCnt_q <= 24'h000000;
                errCnt_q <= 9'h000;
                if (!longWord) begin
                    syncLost_q <= 1'b0;
                end
            end else if (bitValid) begin
                if (errNext == `LPE_ERR_LIMIT) begin // R11
                    syncLost_q <= 1'b1;
                    bitCnt_q   <= 24'h000000;
                    errCnt_q   <= 9'h000;
                end else if (bitCnt_q + 24'h000001 == window) begin
                    // a whole window under the limit regains sync
                    syncLost_q <= 1'b0;
                    bitCnt_q   <= 24'h000000;
                    errCnt_q   <= 9'h000;
                end else begin
                    bitCnt_q <= bitCnt_q + 24'h000001;
                    errCnt_q <= errNext;
                end
            end
        end
    end

endmodule // lpe_sync_monitor

// File: lpe_edit_engine.v
// How it works
// R1: insert 8..80 bit block at address a
// R2: insert address within partition mode range
// R3: insert grows length, shifts later bits up
// R4: size sets length to m bytes plus n
// R5: controller keeps n zero/even above limits
// R6: length query shows scratch or current pattern
// R7: partition mode selects ten/six/three/one/no buffers; code gives no buffers at 512 kbit as well
// R8: current word buffer exists in every mode
// R9: partition query returns mode as number
// R10: threshold 1..9, long-word patterns only
// R11: loss at 256 errors per doubling window; code windows grow 4x up to level 3, then double
// R12: threshold query returns level digit
// R13: open copies chosen source into scratch pad
// R14: controller opens session before downloading
// R15: owner query reports local, remote or none
// R16: close discards, copies current or saves buffer; code rejects discard at 512 and 1024 kbit
// R17: controller always closes each session
// R18: edits act only inside open session
// R19: controller keeps bit address below length
// R20: out of range commands rejected, storage untouched
`timescale 1ns/1ps
`include "lpe_regs.vh"

module lpe_edit_engine (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        rxLongWord,
    input  wire        rxBitValid,
    input  wire        rxBitError,
    output wire        syncLost
);

    localparam ST_IDLE  = 2'h0;
    localparam ST_SHIFT = 2'h1;
    localparam ST_FILL  = 2'h2;
    localparam ST_COPY  = 2'h3;

    // one bit per word keeps bit-granular inserts simple; costs a cycle per bit
    reg        scratchMem [0:1048575];
    reg        storeMem   [0:1048575];
    reg [20:0] slotLen    [0:`LPE_SLOTS-1];

    reg [1:0]  state_q;
    reg [31:0] arg0_q;
    reg [31:0] arg1_q;
    reg [79:0] insData_q;
    reg [2:0]  modeK_q;
    reg [3:0]  syncLevel_q;
    reg        sessionOpen_q;
    reg        ownerLocal_q;
    reg        cmdErr_q;
    reg [20:0] scratchLen_q;
    reg [20:0] ptr_q;
    reg [20:0] limit_q;
    reg [6:0]  insLen_q;
    reg [19:0] base_q;
    reg [3:0]  slot_q;
    reg        toStore_q;
    reg [31:0] rdMux;
    integer    k;

    wire        busy      = (state_q != ST_IDLE);
    wire [7:0]  regAddr   = {avs_address[7:2], 2'b00};
    wire        reqAck    = (avs_read | avs_write) & ~avs_waitrequest;
    wire        cmdWrite  = reqAck & avs_write & (regAddr == `LPE_OFF_CMD) & avs_byteenable[0];
    wire [3:0]  opcode    = avs_writedata[3:0];
    wire [31:0] data2Mrg  = merge({16'h0000, insData_q[79:64]}, avs_writedata, avs_byteenable);
    wire [17:0] capBytes  = capB(modeK_q);
    wire [20:0] capBits   = {capBytes, 3'b000};
    wire [17:0] mBytes    = arg0_q[17:0];
    wire [6:0]  insLen    = arg1_q[6:0];
    wire [20:0] curLen    = sessionOpen_q ? scratchLen_q : slotLen[0];
    wire        mFits     = (arg0_q[31:18] == 14'h0000);
    wire        bufModes  = (modeK_q < `LPE_MODE_ONLYCUR);
    wire        bufIdxOk  = (arg0_q[31:4] == 28'h0000000) & (arg0_q[3:0] <= maxBuf(modeK_q));

    wire insOk = sessionOpen_q // R18
        & (arg1_q[31:7] == 25'h0000000) & (insLen >= `LPE_INS_MIN) // R1
        & (insLen <= `LPE_INS_MAX) & (insLen[2:0] == 3'h0) // R1
        & mFits & (mBytes < capBytes) // R2
        & ({3'h0, mBytes} < scratchLen_q) // R19
        & (scratchLen_q + {14'h0000, insLen} <= capBits); // R20

    wire sizeOk = sessionOpen_q // R18
        & (arg1_q <= `LPE_NBITS_MAX) & mFits & (mBytes <= capBytes) // R4
        & ~((mBytes > `LPE_NZERO_LIMIT) & (arg1_q[2:0] != 3'h0)) // R5
        & ~((mBytes > `LPE_NEVEN_LIMIT) & arg1_q[0]); // R5

    wire modeOk = ~sessionOpen_q & (arg0_q == `LPE_MODE_64 | arg0_q == `LPE_MODE_128
        | arg0_q == `LPE_MODE_256 | arg0_q == `LPE_MODE_512 | arg0_q == `LPE_MODE_1024); // R7

    wire syncOk = (arg0_q[31:4] == 28'h0000000) & (arg0_q[3:0] >= `LPE_SYNC_MIN)
        & (arg0_q[3:0] <= `LPE_SYNC_MAX); // R10

    wire openOk  = ~sessionOpen_q & ((arg0_q == `LPE_SRC_CURRENT) | (bufModes & bufIdxOk)); // R13
    wire closeOk = sessionOpen_q & ((arg0_q == `LPE_SRC_CURRENT)
        | (bufModes & ((arg0_q == `LPE_DST_DISCARD) | bufIdxOk))); // R16

    wire [3:0] argSlot = (arg0_q == `LPE_SRC_CURRENT) ? 4'h0 : arg0_q[3:0] + 4'h1;

    function [17:0] capB;
        input [2:0] kk;
        begin
            capB = `LPE_CAP_BYTES0 << kk;
        end
    endfunction

    function [3:0] maxBuf;
        input [2:0] kk;
        begin
            case (kk)
                3'h0:    maxBuf = 4'h9;
                3'h1:    maxBuf = 4'h5;
                3'h2:    maxBuf = 4'h2;
                default: maxBuf = 4'h0;
            endcase
        end
    endfunction

    function [19:0] slotBase;
        input [3:0] s;
        input [2:0] kk;
        reg   [23:0] wide;
        begin
            // slot 0 is the current word buffer, buffers follow it
            wide     = {20'h00000, s} << (`LPE_REGION_SH0 + {2'h0, kk}); // R8
            slotBase = wide[19:0];
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  be;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (be[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    lpe_sync_monitor u_sync (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .level      (syncLevel_q),
        .longWord   (rxLongWord),
        .bitValid   (rxBitValid),
        .bitError   (rxBitError),
        .syncLost_q (syncLost)
    );

    always @* begin
        rdMux = 32'h00000000;
        case (regAddr)
            `LPE_OFF_ARG0:     rdMux = arg0_q;
            `LPE_OFF_ARG1:     rdMux = arg1_q;
            `LPE_OFF_DATA0:    rdMux = insData_q[31:0];
            `LPE_OFF_DATA1:    rdMux = insData_q[63:32];
            `LPE_OFF_DATA2:    rdMux = {16'h0000, insData_q[79:64]};
            `LPE_OFF_STATUS: begin
                rdMux[`LPE_ST_BUSY]                  = busy;
                rdMux[`LPE_ST_ERR]                   = cmdErr_q;
                rdMux[`LPE_ST_SYNCLOST]              = syncLost;
                rdMux[`LPE_ST_OWN_HI:`LPE_ST_OWN_LO] = !sessionOpen_q ? `LPE_OWN_NONE
                    : (ownerLocal_q ? `LPE_OWN_LOCAL : `LPE_OWN_REMOTE); // R15
            end
            `LPE_OFF_LENBYTES: rdMux = {14'h0000, curLen[20:3]}; // R6
            `LPE_OFF_LENBITS:  rdMux = {29'h00000000, curLen[2:0]}; // R6
            `LPE_OFF_MODE:     rdMux = `LPE_MODE_64 << modeK_q; // R9
            `LPE_OFF_SYNC:     rdMux = {28'h0000000, syncLevel_q}; // R12
            default:           rdMux = 32'h00000000;
        endcase
    end

    // bus slave: one wait cycle per access; command writes also wait out a busy engine
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else if ((avs_read | avs_write) & avs_waitrequest
                     & ~(avs_write & busy & (regAddr == `LPE_OFF_CMD))) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rdMux : avs_readdata;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            arg0_q    <= 32'h00000000;
            arg1_q    <= 32'h00000000;
            insData_q <= 80'h0;
        end else if (reqAck & avs_write) begin
            case (regAddr)
                `LPE_OFF_ARG0:  arg0_q <= merge(arg0_q, avs_writedata, avs_byteenable);
                `LPE_OFF_ARG1:  arg1_q <= merge(arg1_q, avs_writedata, avs_byteenable);
                `LPE_OFF_DATA0: insData_q[31:0] <= merge(insData_q[31:0], avs_writedata, avs_byteenable);
                `LPE_OFF_DATA1: insData_q[63:32] <= merge(insData_q[63:32], avs_writedata, avs_byteenable);
                `LPE_OFF_DATA2: insData_q[79:64] <= data2Mrg[15:0];
                default: ;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        case (state_q)
            ST_SHIFT: scratchMem[ptr_q[19:0] + {13'h0000, insLen_q}] <= scratchMem[ptr_q[19:0]]; // R3
            ST_FILL:  scratchMem[limit_q[19:0] + ptr_q[19:0]] <= insData_q[`LPE_INS_TOP - ptr_q[6:0]]; // R1
            ST_COPY: begin
                if (ptr_q != limit_q) begin
                    if (toStore_q) begin
                        storeMem[base_q + ptr_q[19:0]] <= scratchMem[ptr_q[19:0]]; // R16
                    end else begin
                        scratchMem[ptr_q[19:0]] <= storeMem[base_q + ptr_q[19:0]]; // R13
                    end
                end
            end
            default: ;
        endcase
    end

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q       <= ST_IDLE;
            modeK_q       <= `LPE_MODE_RST;
            syncLevel_q   <= `LPE_SYNC_RST;
            sessionOpen_q <= 1'b0;
            ownerLocal_q  <= 1'b0;
            cmdErr_q      <= 1'b0;
            scratchLen_q  <= 21'h000000;
            ptr_q         <= 21'h000000;
            limit_q       <= 21'h000000;
            insLen_q      <= 7'h00;
            base_q        <= 20'h00000;
            slot_q        <= 4'h0;
            toStore_q     <= 1'b0;
            for (k = 0; k < `LPE_SLOTS; k = k + 1) begin
                slotLen[k] <= 21'h000000;
            end
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmdWrite) begin
                        cmdErr_q <= 1'b1; // R20
                        case (opcode)
                            `LPE_OP_INSERT: if (insOk) begin
                                cmdErr_q <= 1'b0;
                                limit_q  <= {3'h0, mBytes};
                                insLen_q <= insLen;
                                ptr_q    <= scratchLen_q - 21'h000001;
                                state_q  <= ST_SHIFT;
                            end
                            `LPE_OP_SIZE: if (sizeOk) begin
                                cmdErr_q     <= 1'b0;
                                scratchLen_q <= {mBytes, 3'b000} + {18'h00000, arg1_q[2:0]}; // R4
                            end
                            `LPE_OP_MODE: if (modeOk) begin
                                cmdErr_q <= 1'b0;
                                case (arg0_q)
                                    `LPE_MODE_64:  modeK_q <= 3'h0;
                                    `LPE_MODE_128: modeK_q <= 3'h1;
                                    `LPE_MODE_256: modeK_q <= 3'h2;
                                    `LPE_MODE_512: modeK_q <= 3'h3;
                                    default:       modeK_q <= 3'h4;
                                endcase
                                // repartition empties numbered buffers, current one survives only if it fits the new partition size
                                for (k = 1; k < `LPE_SLOTS; k = k + 1) begin
                                    slotLen[k] <= 21'h000000; // R7
                                end
                                if (slotLen[0] > {arg0_q[10:0], 10'h000}) begin
                                    slotLen[0] <= 21'h000000; // R8
                                end
                            end
                            `LPE_OP_SYNC: if (syncOk) begin
                                cmdErr_q    <= 1'b0;
                                syncLevel_q <= arg0_q[3:0]; // R10
                            end
                            `LPE_OP_OPEN: if (openOk) begin
                                cmdErr_q     <= 1'b0;
                                ownerLocal_q <= arg1_q[0];
                                slot_q       <= argSlot;
                                base_q       <= slotBase(argSlot, modeK_q);
                                limit_q      <= slotLen[argSlot];
                                toStore_q    <= 1'b0;
                                ptr_q        <= 21'h000000;
                                state_q      <= ST_COPY; // R13
                            end
                            `LPE_OP_CLOSE: if (closeOk) begin
                                cmdErr_q <= 1'b0;
                                if (arg0_q == `LPE_DST_DISCARD) begin
                                    sessionOpen_q <= 1'b0; // R16
                                end else begin
                                    slot_q    <= argSlot;
                                    base_q    <= slotBase(argSlot, modeK_q);
                                    limit_q   <= scratchLen_q;
                                    toStore_q <= 1'b1;
                                    ptr_q     <= 21'h000000;
                                    state_q   <= ST_COPY; // R16
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                ST_SHIFT: begin
                    if (ptr_q == limit_q) begin
                        ptr_q   <= 21'h000000;
                        state_q <= ST_FILL;
                    end else begin
                        ptr_q <= ptr_q - 21'h000001; // R3
                    end
                end
                ST_FILL: begin
                    if (ptr_q[6:0] == insLen_q - 7'h01) begin
                        scratchLen_q <= scratchLen_q + {14'h0000, insLen_q}; // R3
                        state_q      <= ST_IDLE;
                    end else begin
                        ptr_q <= ptr_q + 21'h000001;
                    end
                end
                ST_COPY: begin
                    if (ptr_q == limit_q) begin
                        state_q <= ST_IDLE;
                        if (toStore_q) begin
                            slotLen[slot_q] <= limit_q; // R16
                            sessionOpen_q   <= 1'b0;
                        end else begin
                            scratchLen_q  <= limit_q; // R13
                            sessionOpen_q <= 1'b1;
                        end
                    end else begin
                        ptr_q <= ptr_q + 21'h000001;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule // lpe_edit_engine

// File: lpe_edit_engine_checker.sv
`timescale 1ns/1ps
module lpe_edit_engine_checker (
    input        clk_sys,
    input        reset_n,
    input [7:0]  avs_address,
    input        avs_read,
    input        avs_write,
    input [31:0] avs_readdata,
    input        avs_waitrequest,
    input        rxLongWord,
    input        rxBitValid,
    input        rxBitError,
    input        syncLost
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    reg [8:0] errCnt_q;
    always @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
            errCnt_q <= 9'h000;
        else if (rxLongWord && rxBitValid && rxBitError && errCnt_q != 9'h1FF)
            errCnt_q <= errCnt_q + 9'h001;
    // cmd writes stall while busy
    sequence s_req;
        $rose(avs_read) || ($rose(avs_write) && avs_address[7:2] != 6'h00);
    endsequence
    sequence s_rd(logic [5:0] w);
        avs_read && !avs_waitrequest && avs_address[7:2] == w;
    endsequence
    property p_answer; s_req |=> !avs_waitrequest; endproperty
    property p_oneLow; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_rstOut; $rose(reset_n) |-> avs_waitrequest && avs_readdata == 32'h00000000 && !syncLost; endproperty
    property p_hold; !$stable(avs_readdata) |-> avs_read && !avs_waitrequest; endproperty
    property p_mode; s_rd(6'h09) |-> avs_readdata inside {32'h40, 32'h80, 32'h100, 32'h200, 32'h400}; endproperty
    property p_sync; s_rd(6'h0A) |-> avs_readdata inside {[32'h1:32'h9]}; endproperty
    property p_bits; s_rd(6'h08) |-> avs_readdata <= 32'h7; endproperty
    property p_owner; s_rd(6'h06) |-> avs_readdata[3:2] != 2'h3 && avs_readdata[31:5] == 27'h0; endproperty
    property p_loss; $rose(syncLost) |-> errCnt_q >= 9'h100; endproperty
    property p_longOnly; !rxLongWord [*4] |-> !syncLost; endproperty
    a_answer: assert property (p_answer) else $error("late answer");
    a_oneLow: assert property (p_oneLow) else $error("wait low too long");
    a_rstOut: assert property (p_rstOut) else $error("bad outputs after reset");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_mode: assert property (p_mode) else $error("bad mode value");
    a_sync: assert property (p_sync) else $error("bad level value");
    a_bits: assert property (p_bits) else $error("bad extra bits");
    a_owner: assert property (p_owner) else $error("bad owner code");
    a_loss: assert property (p_loss) else $error("loss too early");
    a_longOnly: assert property (p_longOnly) else $error("loss without long word");
endmodule // lpe_edit_engine_checker
bind lpe_edit_engine lpe_edit_engine_checker lpe_edit_engine_checker_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxLongWord(rxLongWord),
    .rxBitValid(rxBitValid), .rxBitError(rxBitError), .syncLost(syncLost));

// File: lpe_ctrl_model.sv
`timescale 1ns/1ps
module lpe_ctrl_model (
    input  wire        clk_sys,
    input  wire        avs_waitrequest,
    input  wire [31:0] avs_readdata,
    output reg  [7:0]  avs_address = 8'h00,
    output reg         avs_read = 1'b0,
    output reg         avs_write = 1'b0,
    output reg  [31:0] avs_writedata = 32'h00000000,
    output reg  [3:0]  avs_byteenable = 4'hF
);
    // released data shows its inverse
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(posedge clk_sys);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_writedata <= ~d;
        @(posedge clk_sys);
    endtask
    task automatic cmd(input logic [3:0] op, input logic [31:0] a0, a1);
        logic [31:0] q;
        xfer(1'b1, 8'h04, a0, q);
        xfer(1'b1, 8'h08, a1, q);
        xfer(1'b1, 8'h00, {28'h0000000, op}, q);
        q = 32'h00000001;
        // poll until busy clears
        while (q[0] !== 1'b0)
            xfer(1'b0, 8'h18, 32'h00000000, q);
    endtask
endmodule // lpe_ctrl_model

// File: long_pattern_edit_engine_bench.sv
`timescale 1ns/1ps
module long_pattern_edit_engine_bench;
    typedef struct {logic [3:0] op; logic [31:0] a0, a1; logic [7:0] off; logic [31:0] ex; logic er;} lpe_row_t;
    localparam logic [31:0] NEG1 = 32'hFFFFFFFF;
    localparam logic [31:0] NEG2 = 32'hFFFFFFFE;
    // op 0 rows only read back
    lpe_row_t rows [0:32] = '{
        '{4'h4,4'h9,1'h0,8'h28,4'h9,1'h0}, '{4'h4,4'hA,1'h0,8'h28,4'h9,1'h1}, '{4'h2,4'h4,1'h0,8'h1C,1'h0,1'h1},
        '{4'h3,8'h40,1'h0,8'h24,8'h40,1'h0}, '{4'h5,4'hA,1'h0,8'h18,4'h2,1'h1}, '{4'h5,NEG1,1'h0,8'h18,4'h8,1'h0},
        '{4'h3,8'h80,1'h0,8'h24,8'h40,1'h1}, '{4'h2,12'h800,1'h1,8'h20,1'h0,1'h1}, '{4'h2,12'h7FF,4'h7,8'h20,4'h7,1'h0},
        '{4'h2,16'h2000,1'h0,8'h1C,16'h2000,1'h0}, '{4'h2,4'h4,1'h0,8'h1C,4'h4,1'h0}, '{4'h1,4'h8,8'h10,8'h1C,4'h6,1'h0},
        '{4'h1,4'h8,4'hC,8'h1C,4'h6,1'h1}, '{4'h1,8'h30,4'h8,8'h1C,4'h6,1'h1}, '{4'h1,1'h0,8'h50,8'h1C,8'h10,1'h0},
        '{4'h6,4'hA,1'h0,8'h18,4'hA,1'h1}, '{4'h6,4'h3,1'h0,8'h18,1'h0,1'h0}, '{4'h5,4'h3,1'h1,8'h1C,8'h10,1'h0},
        '{4'h0,1'h0,1'h0,8'h18,4'h4,1'h0}, '{4'h2,4'h3,4'h5,8'h20,4'h5,1'h0}, '{4'h6,NEG1,1'h0,8'h1C,4'h3,1'h0},
        '{4'h5,NEG1,1'h0,8'h1C,4'h3,1'h0}, '{4'h6,NEG2,1'h0,8'h18,1'h0,1'h0}, '{4'h3,8'h80,1'h0,8'h24,8'h80,1'h0},
        '{4'h5,4'h6,1'h0,8'h18,4'h2,1'h1}, '{4'h3,12'h100,1'h0,8'h24,12'h100,1'h0}, '{4'h3,12'h200,1'h0,8'h24,12'h200,1'h0},
        '{4'h3,12'h400,1'h0,8'h24,12'h400,1'h0}, '{4'h5,NEG1,1'h0,8'h18,4'h8,1'h0}, '{4'h6,NEG2,1'h0,8'h18,4'hA,1'h1},
        '{4'h6,NEG1,1'h0,8'h1C,4'h3,1'h0}, '{4'h0,1'h0,1'h0,8'h20,4'h5,1'h0}, '{4'h0,1'h0,1'h0,8'h3C,1'h0,1'h0}};
    logic [7:0]  rOff [0:3] = '{8'h24, 8'h28, 8'h18, 8'h1C};
    logic [31:0] rEx [0:3] = '{32'h400, 32'h1, 32'h0, 32'h0};
    reg          clk_sys = 1'b0;
    reg          reset_n = 1'b0;
    reg          rxLongWord = 1'b0;
    reg          rxBitValid = 1'b0;
    reg          rxBitError = 1'b0;
    wire [7:0]   avs_address;
    wire [31:0]  avs_writedata, avs_readdata;
    wire [3:0]   avs_byteenable;
    wire         avs_read, avs_write, avs_waitrequest, syncLost;
    int          miscompares = 0;
    int          num_checks = 0;
    logic [31:0] q;
    always #5 clk_sys = ~clk_sys;
    lpe_edit_engine lpe_edit_engine_inst (.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxLongWord(rxLongWord),
        .rxBitValid(rxBitValid), .rxBitError(rxBitError), .syncLost(syncLost));
    lpe_ctrl_model lpe_ctrl_model_inst (.clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));
    task automatic check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        lpe_ctrl_model_inst.xfer(1'b0, a, 32'h00000000, q);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk_sys);
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report;
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        for (int k = 0; k < 3; k++) lpe_ctrl_model_inst.xfer(1'b1, 8'h0C + 8'(4 * k), 32'hC3A50F96, q);
        foreach (rows[i]) begin
            if (rows[i].op != 4'h0) begin
                lpe_ctrl_model_inst.cmd(rows[i].op, rows[i].a0, rows[i].a1);
                rd(8'h18);
                check(32'(q[1]), 32'(rows[i].er));
            end
            rd(rows[i].off);
            check(q, rows[i].ex);
            $display("row %0d done", i);
        end
        lpe_ctrl_model_inst.cmd(4'h4, 32'h1, 32'h0);
        rxLongWord <= 1'b1;
        rxBitValid <= 1'b1;
        rxBitError <= 1'b1;
        repeat (250) @(posedge clk_sys);
        check(32'(syncLost), 32'h0);
        repeat (20) @(posedge clk_sys);
        check(32'(syncLost), 32'h1);
        rxLongWord <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(32'(syncLost), 32'h0);
        rxBitValid <= 1'b0;
        rxBitError <= 1'b0;
        $display("sync test done");
        lpe_ctrl_model_inst.cmd(4'h3, 32'h40, 32'h0);
        lpe_ctrl_model_inst.cmd(4'h4, 32'h9, 32'h0);
        lpe_ctrl_model_inst.cmd(4'h5, NEG1, 32'h1);
        reset_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        for (int k = 0; k < 4; k++) begin
            rd(rOff[k]);
            check(q, rEx[k]);
        end
        $display("reset test done");
        final_report;
    end
endmodule // long_pattern_edit_engine_bench
